/* rtl/eeprom_pkg.sv */
package eeprom_pkg;
    // Array and page geometry
    localparam int ADDR_W = 10;
    localparam int PAGE_W = 4;
    localparam int SN_BYTES = 16;
    localparam int SN_BITS = 128;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;

    // Device address byte layout
    localparam logic [3:0] TYPE_ARRAY = 4'hA;
    localparam logic [3:0] TYPE_SERIAL = 4'hB;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int HW_SEL_POS = 3;
    localparam int TOP_BIT_POS = 2;
    localparam int SECOND_BIT_POS = 1;
    localparam int RW_POS = 0;

    // Word address tag that selects valid serial-number data
    localparam logic [1:0] SN_TAG = 2'h2;
    localparam int SN_TAG_MSB = 7;
    localparam int SN_TAG_LSB = 6;

    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam logic [9:0] PTR_RESET = 10'h000;

    // Value is arbitrary; a real part carries a factory-unique number
    localparam logic [127:0] SERIAL_DEFAULT = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;

    // Self-timed write cycle
    localparam int T_WR_NS = 5000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;

    // Pin order inside the synchroniser
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_WP = 2;
    localparam int PIN_HWSEL = 3;
    localparam int PIN_COUNT = 4;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_WORD,
        ST_WORD_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WRITE
    } ctrl_state_t;
endpackage

/* rtl/eeprom_ifs.sv */
`timescale 1ns/100ps

interface pin_events_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_lvl;
    logic wp_lvl;
    logic hw_select_bit;

    modport front (
        output scl_rise, scl_fall, start_det, stop_det, sda_lvl, wp_lvl, hw_select_bit
    );
    modport core (
        input scl_rise, scl_fall, start_det, stop_det, sda_lvl, wp_lvl, hw_select_bit
    );
endinterface

interface stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport sink (input valid, data, output ready);
    modport source (output valid, data, input ready);
endinterface

/* rtl/pin_sync.sv */
`timescale 1ns/100ps

module pin_sync
    import eeprom_pkg::*;
(
    input wire logic mclk,                        // System clock
    input wire logic rst_n,                       // Synchronous reset, active low
    input wire logic [PIN_COUNT-1:0] pins,        // Raw pins: scl, sda, wp, hw select
    pin_events_if.front ev                        // Filtered levels and bus events
);
    logic [PIN_COUNT-1:0] lvl_q;
    logic [PIN_COUNT-1:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                    s3_q <= 1'b1;
                    lvl_q[i] <= 1'b1;
                    prev_q[i] <= 1'b1;
                end else begin
                    s1_q <= pins[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A change is taken only once two late stages agree
                    if (s2_q == s3_q) begin
                        lvl_q[i] <= s3_q;
                    end
                    prev_q[i] <= lvl_q[i];
                end
            end
        end
    endgenerate

    assign ev.scl_rise = lvl_q[PIN_SCL] & ~prev_q[PIN_SCL];
    assign ev.scl_fall = ~lvl_q[PIN_SCL] & prev_q[PIN_SCL];
    assign ev.start_det = lvl_q[PIN_SCL] & prev_q[PIN_SCL] & prev_q[PIN_SDA] & ~lvl_q[PIN_SDA];
    assign ev.stop_det = lvl_q[PIN_SCL] & prev_q[PIN_SCL] & ~prev_q[PIN_SDA] & lvl_q[PIN_SDA];
    assign ev.sda_lvl = lvl_q[PIN_SDA];
    assign ev.wp_lvl = lvl_q[PIN_WP];
    assign ev.hw_select_bit = lvl_q[PIN_HWSEL];
endmodule

/* rtl/byte_fifo.sv */
`timescale 1ns/100ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,      // System clock
    input wire logic rst_n,     // Synchronous reset, active low
    input wire logic clear,     // Drop all stored words
    stream_if.sink wr,          // Filling side
    stream_if.source rd         // Draining side
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic do_wr;
    logic do_rd;

    assign wr.ready = (count_q != (AW+1)'(DEPTH));
    assign rd.valid = (count_q != '0);
    assign rd.data = store[rd_ptr_q];
    assign do_wr = wr.valid & wr.ready;
    assign do_rd = rd.valid & rd.ready;

    always_ff @(posedge mclk) begin
        if (do_wr) begin
            store[wr_ptr_q] <= wr.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || clear) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

/* rtl/eeprom_target.sv */
// Functional notes
// - Write-protect high refuses all array writes; low or floating protects nothing.
// - Protect level taken at the write's Stop; later changes leave the cycle alone.
// - Protected write still acks every byte (code leaves data bytes past the 16th unacked); no cycle starts, ready at once.
// - One pointer serves array and serial region; controller dummy-writes when switching.
// - Pointer holds last accessed address plus one, kept between operations.
// - Array reads wrap from last byte of last page to address zero.
// - Current address read acks the address then shifts out the pointed byte.
// - Any read ends when the controller does not ack in the ninth clock.
// - Read-direction address ignores its array top bits; pointer decides.
// - Acked reads increment and continue, wrapping past the highest address.
// - Serial word address needs binary 10 in bits seven and six.
// - Serial reading wraps from the sixteenth byte back to the first.
// - Unwritten array locations read as all ones.
// - Device address bit zero selects read when one, write when zero.
// - Device address bits two and one give the top two array bits.
// - Word address byte gives the low eight array address bits.
// - During a write cycle every device address is left unacknowledged.
`timescale 1ns/100ps

module eeprom_target
    import eeprom_pkg::*;
#(
    parameter int WR_WAIT = eeprom_pkg::WR_CYCLES,              // Self-timed write length
    parameter logic [127:0] SERIAL_NUMBER = eeprom_pkg::SERIAL_DEFAULT // Arbitrary value
) (
    input wire logic mclk,          // 250 MHz system clock
    input wire logic rst_n,         // Synchronous reset, active low
    input wire logic scl_i,         // Bus clock pin
    input wire logic sda_i,         // Bus data pin level
    output logic sda_o,             // Bus data drive value, always low
    output logic sda_oe_n,          // Low while pulling the data line low
    input wire logic wp_i,          // Write-protect pin
    input wire logic hw_select_i,   // Hardware slave address pin
    output logic write_busy         // High during the self-timed write cycle
);
    import eeprom_pkg::*;

    localparam int TW = $clog2(WR_WAIT + 1);

    pin_events_if ev ();
    stream_if #(.WIDTH(BYTE_W)) fin ();
    stream_if #(.WIDTH(BYTE_W)) fout ();

    ctrl_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [1:0] dev_hi_q;
    logic serial_q;
    logic master_ack_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic wr_pending_q;
    logic flush_q;
    logic [TW-1:0] wr_timer_q;
    logic sda_oe_n_q;
    logic sda_o_q;
    logic write_busy_q;
    // Erased contents sit in the initialiser so the write process stays the only writer
    logic [7:0] mem [2**ADDR_W] = '{default: ERASED_BYTE};

    logic [3:0] dev_type;
    logic dev_match;
    logic byte_done;
    logic rx_accept;
    logic wr_done;
    logic [7:0] rd_byte;
    logic [ADDR_W-1:0] page_inc;
    logic [ADDR_W-1:0] read_inc;

    // Serial byte zero is the most significant byte of the number
    function automatic logic [7:0] sn_byte(input logic [3:0] idx);
        sn_byte = SERIAL_NUMBER[SN_BITS - 1 - BYTE_W * int'(idx) -: BYTE_W];
    endfunction

    pin_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pins({hw_select_i, wp_i, sda_i, scl_i}),
        .ev(ev)
    );

    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(1'b0),
        .wr(fin),
        .rd(fout)
    );

    assign dev_type = shift_q[TYPE_MSB:TYPE_LSB];
    assign dev_match = ((dev_type == TYPE_ARRAY) || (dev_type == TYPE_SERIAL))
        && (shift_q[HW_SEL_POS] == ev.hw_select_bit);
    assign byte_done = ev.scl_fall && (bit_cnt_q == LAST_BIT);

    // Data bytes are held back when the page buffer is full
    assign rx_accept = serial_q || fin.ready;
    assign fin.valid = (state_q == ST_RX) && byte_done && !serial_q;
    assign fin.data = shift_q;

    // Buffer drains only during the write cycle or to discard a refused or abandoned page
    assign fout.ready = (state_q == ST_WRITE) || flush_q;
    assign wr_done = (state_q == ST_WRITE) && (wr_timer_q == TW'(WR_WAIT - 1)) && !fout.valid;

    // Serial region keeps its upper pointer bits and wraps within 16 bytes
    assign page_inc = {ptr_q[ADDR_W-1:PAGE_W], ptr_q[PAGE_W-1:0] + 1'b1};
    assign read_inc = serial_q ? page_inc : ptr_q + 1'b1;

    always_comb begin
        if (serial_q) begin
            if (ptr_q[SN_TAG_MSB:SN_TAG_LSB] == SN_TAG) begin
                rd_byte = sn_byte(ptr_q[PAGE_W-1:0]);
            end else begin
                // Undefined serial data reads as erased rather than unknown
                rd_byte = ERASED_BYTE;
            end
        end else begin
            rd_byte = mem[ptr_q];
        end
    end

    // Bus protocol sequencing
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            master_ack_q <= 1'b0;
        end else if (state_q == ST_WRITE) begin
            // Bus is ignored entirely until the write cycle finishes
            if (wr_done) begin
                state_q <= ST_IDLE;
            end
        end else if (ev.start_det) begin
            state_q <= ST_DEV;
            bit_cnt_q <= 4'h0;
        end else if (ev.stop_det) begin
            if (wr_pending_q && !ev.wp_lvl) begin
                state_q <= ST_WRITE;
            end else begin
                state_q <= ST_IDLE;
            end
        end else begin
            case (state_q)
                ST_DEV, ST_WORD, ST_RX: begin
                    if (ev.scl_rise) begin
                        shift_q <= {shift_q[6:0], ev.sda_lvl};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_DEV) begin
                            state_q <= dev_match ? ST_DEV_ACK : ST_IDLE;
                        end else if (state_q == ST_WORD) begin
                            state_q <= ST_WORD_ACK;
                        end else begin
                            state_q <= ST_RX_ACK;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (ev.scl_fall) begin
                        if (shift_q[RW_POS]) begin
                            state_q <= ST_TX;
                            shift_q <= rd_byte;
                        end else begin
                            state_q <= ST_WORD;
                        end
                    end
                end
                ST_WORD_ACK, ST_RX_ACK: begin
                    if (ev.scl_fall) begin
                        state_q <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (ev.scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (ev.scl_fall) begin
                        if (bit_cnt_q == LAST_BIT) begin
                            state_q <= ST_TX_ACK;
                            bit_cnt_q <= 4'h0;
                        end else if (bit_cnt_q != 4'h0) begin
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (ev.scl_rise) begin
                        master_ack_q <= !ev.sda_lvl;
                    end else if (ev.scl_fall) begin
                        if (master_ack_q) begin
                            state_q <= ST_TX;
                            shift_q <= rd_byte;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Shared address pointer and region select
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ptr_q <= PTR_RESET;
            dev_hi_q <= 2'b00;
            serial_q <= 1'b0;
        end else if (state_q != ST_WRITE && !ev.start_det && !ev.stop_det) begin
            if (state_q == ST_DEV && byte_done && dev_match) begin
                serial_q <= (dev_type == TYPE_SERIAL);
                // A read-direction address leaves the pointer alone
                if (!shift_q[RW_POS]) begin
                    dev_hi_q <= (dev_type == TYPE_SERIAL) ? 2'b00
                        : {shift_q[TOP_BIT_POS], shift_q[SECOND_BIT_POS]};
                end
            end
            if (state_q == ST_WORD && byte_done) begin
                ptr_q <= {dev_hi_q, shift_q};
            end
            if (fin.valid && fin.ready) begin
                ptr_q <= page_inc;
            end
            if (state_q == ST_TX && ev.scl_fall && bit_cnt_q == LAST_BIT) begin
                ptr_q <= read_inc;
            end
        end
    end

    // Self-timed cycle counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_timer_q <= '0;
        end else if (state_q == ST_WRITE) begin
            wr_timer_q <= (wr_timer_q == TW'(WR_WAIT - 1)) ? wr_timer_q : wr_timer_q + 1'b1;
        end else begin
            wr_timer_q <= '0;
        end
    end

    // Page start address, stepped within its page as the buffer drains
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_addr_q <= PTR_RESET;
        end else if (state_q == ST_WORD && byte_done) begin
            wr_addr_q <= {dev_hi_q, shift_q};
        end else if (fout.valid && fout.ready && state_q == ST_WRITE) begin
            wr_addr_q <= {wr_addr_q[ADDR_W-1:PAGE_W], wr_addr_q[PAGE_W-1:0] + 1'b1};
        end
    end

    // Data accepted since the last Start or Stop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_pending_q <= 1'b0;
        end else if (state_q != ST_WRITE && (ev.start_det || ev.stop_det)) begin
            wr_pending_q <= 1'b0;
        end else if (fin.valid && fin.ready) begin
            wr_pending_q <= 1'b1;
        end
    end

    // A refused or abandoned page is thrown away; a new refusal outranks the clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flush_q <= 1'b0;
        end else if (state_q != ST_WRITE && (ev.start_det || ev.stop_det)
            && wr_pending_q && (ev.start_det || ev.wp_lvl)) begin
            flush_q <= 1'b1;
        end else if (!fout.valid) begin
            flush_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (state_q == ST_WRITE && fout.valid) begin
            mem[wr_addr_q] <= fout.data;
        end
    end

    // Busy flag drops in the cycle the self-timed write completes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            write_busy_q <= 1'b0;
        end else begin
            write_busy_q <= (state_q == ST_WRITE) && !wr_done;
        end
    end

    // Open-drain data line: release for one, pull low for zero or acknowledge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sda_oe_n_q <= 1'b1;
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
            if (state_q == ST_WRITE || ev.start_det || ev.stop_det) begin
                sda_oe_n_q <= 1'b1;
            end else if (byte_done && state_q == ST_DEV) begin
                sda_oe_n_q <= !dev_match;
            end else if (byte_done && state_q == ST_WORD) begin
                sda_oe_n_q <= 1'b0;
            end else if (byte_done && state_q == ST_RX) begin
                sda_oe_n_q <= !rx_accept;
            end else if (ev.scl_fall) begin
                case (state_q)
                    ST_DEV_ACK: begin
                        sda_oe_n_q <= shift_q[RW_POS] ? rd_byte[7] : 1'b1;
                    end
                    ST_TX: begin
                        if (bit_cnt_q == LAST_BIT) begin
                            sda_oe_n_q <= 1'b1;
                        end else if (bit_cnt_q != 4'h0) begin
                            sda_oe_n_q <= shift_q[6];
                        end
                    end
                    ST_TX_ACK: begin
                        sda_oe_n_q <= master_ack_q ? rd_byte[7] : 1'b1;
                    end
                    default: begin
                        sda_oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign sda_oe_n = sda_oe_n_q;
    assign sda_o = sda_o_q;
    assign write_busy = write_busy_q;
endmodule

/* verif/eeprom_checker.sv */
`timescale 1ns/100ps

module eeprom_checker #(
    parameter int WR_WAIT = 50
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic wp_i,
    input wire logic hw_select_i,
    input wire logic write_busy
);
    logic scl_q, sda_q;
    logic [3:0] fall_cnt_q;
    logic [4:0] stop_cnt_q;
    logic [31:0] busy_cnt_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge mclk) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
    end

    // Cycles since the bus clock pin fell, saturating
    always_ff @(posedge mclk) begin
        if (!rst_n) fall_cnt_q <= 4'hF;
        else if (scl_q && !scl_i) fall_cnt_q <= 4'h0;
        else if (fall_cnt_q != 4'hF) fall_cnt_q <= fall_cnt_q + 4'h1;
    end

    // Cycles since a Stop on the pins, saturating
    always_ff @(posedge mclk) begin
        if (!rst_n) stop_cnt_q <= 5'h1F;
        else if (scl_i && scl_q && sda_i && !sda_q) stop_cnt_q <= 5'h00;
        else if (stop_cnt_q != 5'h1F) stop_cnt_q <= stop_cnt_q + 5'h01;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !write_busy) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    property p_busy_quiet;
        write_busy |-> sda_oe_n;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("data line driven during write cycle");
    property p_oe_scl_low;
        $changed(sda_oe_n) |-> !scl_i;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data drive changed while bus clock high");
    property p_oe_after_fall;
        $changed(sda_oe_n) |-> fall_cnt_q >= 4'h1 && fall_cnt_q <= 4'hA;
    endproperty
    a_oe_after_fall: assert property (p_oe_after_fall)
        else $error("data drive changed away from a clock fall");
    property p_busy_after_stop;
        $rose(write_busy) |-> stop_cnt_q <= 5'h10;
    endproperty
    a_busy_after_stop: assert property (p_busy_after_stop)
        else $error("write cycle began without a Stop");
    property p_busy_wp;
        $rose(write_busy) |-> !$past(wp_i, 8);
    endproperty
    a_busy_wp: assert property (p_busy_wp)
        else $error("write cycle began while protected");
    property p_busy_len;
        $fell(write_busy) |-> busy_cnt_q >= WR_WAIT - 2 && busy_cnt_q <= WR_WAIT + 2;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    property p_busy_hold;
        $rose(write_busy) |=> write_busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("write cycle cut short");
    property p_drive_low;
        !sda_oe_n |-> !sda_o;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("data line driven high");

    cover property ($rose(write_busy));
    cover property ($fell(sda_oe_n));
    cover property (wp_i && scl_i && $rose(sda_i));
endmodule

bind eeprom_target eeprom_checker #(.WR_WAIT(WR_WAIT)) chk (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wp_i(wp_i), .hw_select_i(hw_select_i), .write_busy(write_busy)
);

/* verif/i2c_host.sv */
`timescale 1ns/100ps

module i2c_host (
    input wire logic mclk,     // System clock
    input wire logic sda_line, // Resolved data wire
    output logic scl,          // Bus clock, high when idle
    output logic sda           // Data drive, 1 releases to the pull-up
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Quarter bus period keeps every pin edge 8 cycles apart
    task automatic q;
        repeat (8) @(posedge mclk);
    endtask

    task automatic start;
        q();
        sda <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        q();
        sda <= 1'b0;
        q();
        q();
        scl <= 1'b0;
    endtask

    task automatic stop;
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        q();
        sda <= 1'b1;
        q();
        q();
    endtask

    task automatic clk_bit(input logic b, output logic r);
        q();
        sda <= b;
        q();
        scl <= 1'b1;
        q();
        r = sda_line;
        q();
        scl <= 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = ~r;
    endtask

    // Last byte gets no acknowledge, which ends the read
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(last, r);
    endtask
endmodule

/* verif/eeprom_target_bench.sv */
`timescale 1ns/100ps

module eeprom_target_bench;
    import eeprom_pkg::*;
    localparam int WAIT = 600;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_i = 1'b0;
    logic hw_select_i = 1'b1;
    logic sda_o, sda_oe_n, write_busy, scl, host_sda, ack;
    wire logic sda_line = (sda_oe_n | sda_o) & host_sda;
    int bad_count = 0;
    int compares = 0;
    logic [7:0] rx [0:16];

    always #2 mclk = ~mclk;

    eeprom_target #(.WR_WAIT(WAIT)) dut (
        .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .wp_i(wp_i), .hw_select_i(hw_select_i), .write_busy(write_busy)
    );
    i2c_host host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(host_sda));

    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Start, write-direction address and word address, no Stop
    task automatic addr_set(input logic [3:0] ty, input logic [9:0] a);
        host.start();
        host.wbyte({ty, 1'b1, a[9:8], 1'b0}, ack);
        chk_bit("device ack", 1'b1, ack);
        host.wbyte(a[7:0], ack);
        chk_bit("word ack", 1'b1, ack);
    endtask

    task automatic rd(input logic [3:0] ty, input int n);
        host.start();
        host.wbyte({ty, 1'b1, 2'b01, 1'b1}, ack);
        chk_bit("read ack", 1'b1, ack);
        for (int i = 0; i < n; i++) host.rbyte(i == n - 1, rx[i]);
        host.stop();
    endtask

    task automatic t_write;
        addr_set(TYPE_ARRAY, 10'h3FF);
        host.wbyte(8'h5A, ack);
        chk_bit("data ack", 1'b1, ack);
        host.wbyte(8'hC3, ack);
        chk_bit("data ack", 1'b1, ack);
        host.stop();
        repeat (20) @(posedge mclk);
        chk_bit("busy", 1'b1, write_busy);
        wp_i <= 1'b1;
        host.start();
        host.wbyte({TYPE_ARRAY, 1'b1, 2'b00, 1'b0}, ack);
        chk_bit("busy ack", 1'b0, ack);
        host.stop();
        wp_i <= 1'b0;
        for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) @(posedge mclk);
        chk_bit("busy end", 1'b0, write_busy);
        addr_set(TYPE_ARRAY, 10'h3FE);
        rd(TYPE_ARRAY, 1);
        chk_byte("erased byte", ERASED_BYTE, rx[0]);
        rd(TYPE_ARRAY, 2);
        chk_byte("current byte", 8'h5A, rx[0]);
        chk_byte("wrapped byte", ERASED_BYTE, rx[1]);
        $display("test write done");
    endtask

    task automatic t_protect;
        wp_i <= 1'b1;
        repeat (10) @(posedge mclk);
        addr_set(TYPE_ARRAY, 10'h3F0);
        host.wbyte(8'h00, ack);
        chk_bit("protected data ack", 1'b1, ack);
        host.stop();
        repeat (20) @(posedge mclk);
        chk_bit("protected busy", 1'b0, write_busy);
        wp_i <= 1'b0;
        addr_set(TYPE_ARRAY, 10'h3F0);
        rd(TYPE_ARRAY, 1);
        chk_byte("kept byte", 8'hC3, rx[0]);
        $display("test protect done");
    endtask

    task automatic t_serial;
        addr_set(TYPE_SERIAL, 10'h080);
        rd(TYPE_SERIAL, 17);
        for (int i = 0; i < 17; i++) begin
            chk_byte("serial byte", SERIAL_DEFAULT[127 - 8 * (i % 16) -: 8], rx[i]);
        end
        chk_bit("serial busy", 1'b0, write_busy);
        addr_set(TYPE_SERIAL, 10'h040);
        rd(TYPE_SERIAL, 1);
        chk_byte("untagged byte", ERASED_BYTE, rx[0]);
        $display("test serial done");
    endtask

    task automatic test_done;
        $display("compares %0d, bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        t_write();
        t_protect();
        t_serial();
        test_done();
    end

    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
